// >>> design/ombc_top.sv
`timescale 1ns/1ps
`include "ombc_regs.svh"
module ombc_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [4:0]  p2_pin_in,
   input  wire logic [7:0]  p3_pin_in,
   output logic [7:0]       p3_pin_out,
   output logic [7:0]       p3_pin_oe,
   input  wire logic [7:0]  p4_pin_in,
   output logic [7:0]       p4_pin_out,
   output logic [7:0]       p4_pin_oe,
   output logic             p4_pullup_en,
   output logic             e_clk,
   output logic             addr_latch_strobe,
   output logic             io_page_select,
   output logic             bus_rd_wn,
   output logic [2:0]       mode,
   output logic [15:0]      vector_base,
   output logic [15:0]      reg_base,
   output logic             bus_join
);
   import ombc_pkg::*;

   logic [4:0]     p2_meta, p2_sync;
   logic [7:0]     p3_meta, p3_sync, p4_meta, p4_sync;
   logic           rst_seen;
   logic [2:0]     mode_bits;
   logic [7:0]     p3_dir, p4_dir, p3_data, p4_data;
   ombc_bus_req_t  req;
   logic           busy;
   logic [7:0]     rd_byte;
   logic           as_int, e_int, e_last, e_mid;
   ombc_bus_kind_t bus_kind;
   ombc_pin_drv_t  p3_drv, p4_drv;

   // Two flops on every pin before logic looks at it
   // No reset here: the mode pins must already be settled when reset releases
   always_ff @(posedge pclk) begin
      p2_meta <= p2_pin_in;
      p2_sync <= p2_meta;
      p3_meta <= p3_pin_in;
      p3_sync <= p3_meta;
      p4_meta <= p4_pin_in;
      p4_sync <= p4_meta;
   end

   // APB decode
   wire acc       = psel && penable;
   wire wr_acc    = acc && pwrite;
   wire hit_p2    = (paddr == `OMBC_ADDR_P2_DATA);
   wire hit_p3d   = (paddr == `OMBC_ADDR_P3_DATA);
   wire hit_p3dir = (paddr == `OMBC_ADDR_P3_DIR);
   wire hit_p4d   = (paddr == `OMBC_ADDR_P4_DATA);
   wire hit_p4dir = (paddr == `OMBC_ADDR_P4_DIR);
   wire hit_req   = (paddr == `OMBC_ADDR_BUS_REQ);
   wire hit_stat  = (paddr == `OMBC_ADDR_BUS_STAT);
   wire hit_map   = (paddr == `OMBC_ADDR_MAP_STAT);
   wire mapped    = hit_p2 | hit_p3d | hit_p3dir | hit_p4d | hit_p4dir | hit_req | hit_stat | hit_map;
   // Direction registers are write-only, so a read there is refused too
   wire bad_rd    = !pwrite && (hit_p3dir || hit_p4dir);
   assign pready  = 1'b1;
   assign pslverr = acc && (!mapped || bad_rd);

   // Mode taken at the first clock after reset release, then locked apart from the one exit from test mode
   // Pins are synchronised, so the value is the level seen two clocks before.
   wire [2:0] new_mode  = pwdata[`OMBC_P2_MODE_LSB +: 3];
   wire       mode_wr   = wr_acc && hit_p2 && (mode_bits == `OMBC_MODE_TEST) && rst_seen;
   wire       mode_ok   = (new_mode == `OMBC_MODE_NMUX) || (new_mode == `OMBC_MODE_MUX_PART)
                          || (new_mode == `OMBC_MODE_SINGLE);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_seen  <= 1'b0;
         mode_bits <= 3'h0;
      end else if (!rst_seen) begin
         rst_seen  <= 1'b1;
         mode_bits <= p2_sync[2:0];
      end else if (mode_wr && mode_ok) begin
         mode_bits <= new_mode;                            // one way out of test mode
      end
   end
   assign mode = mode_bits;

   // Bus kind from the mode number
   assign bus_kind = (mode_bits == `OMBC_MODE_SINGLE)  ? OMBC_BUS_SINGLE :
                     (mode_bits == `OMBC_MODE_NMUX)    ? OMBC_BUS_NMUX   :
                     (mode_bits == `OMBC_MODE_NONUSER) ? OMBC_BUS_NONE   : OMBC_BUS_MUX;
   wire p4_full_addr = (mode_bits == `OMBC_MODE_TEST) || (mode_bits == `OMBC_MODE_RAM_EXT)
                       || (mode_bits == `OMBC_MODE_RELOC);

   // Map outputs: vectors, register block, bus join
   assign vector_base = (mode_bits == `OMBC_MODE_TEST) ? `OMBC_VEC_BASE_TEST : `OMBC_VEC_BASE_NORM;
   assign reg_base    = (mode_bits == `OMBC_MODE_RELOC) ? `OMBC_REG_BASE_RELOC : `OMBC_REG_BASE_NORM;
   assign bus_join    = (mode_bits == `OMBC_MODE_TEST);

   // Port registers and the external cycle request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p3_dir  <= `OMBC_DIR_RESET;
         p4_dir  <= `OMBC_DIR_RESET;
         p3_data <= `OMBC_DATA_RESET;
         p4_data <= `OMBC_DATA_RESET;
         req     <= '0;
      end else begin
         if (wr_acc && hit_p3dir) p3_dir  <= pwdata[7:0];
         if (wr_acc && hit_p4dir) p4_dir  <= pwdata[7:0];
         if (wr_acc && hit_p3d)   p3_data <= pwdata[7:0];
         if (wr_acc && hit_p4d)   p4_data <= pwdata[7:0];
         if (wr_acc && hit_req && !busy && (bus_kind == OMBC_BUS_NMUX || bus_kind == OMBC_BUS_MUX)) begin
            req.go    <= pwdata[`OMBC_BUS_GO_BIT];
            req.wr    <= pwdata[`OMBC_BUS_WR_BIT];
            req.addr  <= pwdata[15:0];
            req.wdata <= pwdata[31:24];
         end else if (busy && e_last) begin
            req.go <= 1'b0;
         end
      end
   end

   // A request waits for the start of an E cycle, then owns it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy <= 1'b0;
      end else if (busy && e_last) begin
         busy <= 1'b0;
      end else if (!busy && req.go && e_last) begin
         busy <= 1'b1;
      end
   end

   // Read data captured at the E fall while the memory drives
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_byte <= 8'h00;
      end else if (busy && e_last && !req.wr) begin
         rd_byte <= p3_sync;
      end
   end

   ombc_ecycle u_ecycle (
      .pclk      (pclk),
      .presetn   (presetn),
      .req       (req),
      .busy_in   (busy && (bus_kind == OMBC_BUS_MUX)),
      .e_clk     (e_int),
      .as_strobe (as_int),
      .e_last    (e_last),
      .e_mid     (e_mid)
   );
   assign e_clk             = e_int;
   assign addr_latch_strobe = as_int;

   // Port 3 drive by bus kind
   // Address released one pclk before E rises, as pin flops lag; memory owns E high on reads
   wire p3_addr_phase = busy && !e_int && !e_mid;
   always_comb begin
      p3_drv = '0;
      case (bus_kind)
         OMBC_BUS_SINGLE: begin
            p3_drv.o  = p3_data;
            p3_drv.oe = p3_dir;
         end
         OMBC_BUS_NMUX: begin
            p3_drv.o  = req.wdata;
            p3_drv.oe = (busy && req.wr && e_int) ? 8'hff : 8'h00;
         end
         OMBC_BUS_MUX: begin
            p3_drv.o  = p3_addr_phase ? req.addr[7:0] : req.wdata;
            p3_drv.oe = (p3_addr_phase || (busy && req.wr && e_int)) ? 8'hff : 8'h00;
         end
         default: p3_drv = '0;
      endcase
   end

   // Port 4 drive by mode
   always_comb begin
      p4_drv = '0;
      case (bus_kind)
         OMBC_BUS_SINGLE: begin
            p4_drv.o  = p4_data;
            p4_drv.oe = p4_dir;
         end
         OMBC_BUS_NMUX: begin
            p4_drv.o  = req.addr[7:0];
            p4_drv.oe = p4_dir;
         end
         OMBC_BUS_MUX: begin
            p4_drv.o  = req.addr[15:8];
            p4_drv.oe = p4_full_addr ? 8'hff : p4_dir;
         end
         default: p4_drv = '0;
      endcase
   end

   // Undriven port 4 lines float high through pull-ups in modes 1, 5 and 6 (0xffxx in mode 1)
   assign p4_pullup_en = (bus_kind == OMBC_BUS_NMUX) || (bus_kind == OMBC_BUS_MUX && !p4_full_addr);

   // Pins outputs held in flops so they never glitch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p3_pin_out     <= 8'h00;
         p3_pin_oe      <= 8'h00;
         p4_pin_out     <= 8'h00;
         p4_pin_oe      <= 8'h00;
         io_page_select <= 1'b0;
         bus_rd_wn      <= 1'b1;
      end else begin
         p3_pin_out     <= p3_drv.o;
         p3_pin_oe      <= p3_drv.oe;
         p4_pin_out     <= p4_drv.o;
         p4_pin_oe      <= p4_drv.oe;
         io_page_select <= busy && (bus_kind == OMBC_BUS_NMUX) && (req.addr[15:8] == `OMBC_IO_PAGE_HI);
         bus_rd_wn      <= !(busy && req.wr);
      end
   end

   // Read mux
   always_comb begin
      prdata = 32'h0000_0000;
      if (acc && !pwrite) begin
         if (hit_p2)   prdata = {24'h000000, mode_bits, p2_sync};
         if (hit_p3d)  prdata = {24'h000000, (p3_dir & p3_data) | (~p3_dir & p3_sync)};
         if (hit_p4d)  prdata = {24'h000000, (p4_dir & p4_data) | (~p4_dir & p4_sync)};
         if (hit_stat) prdata = {15'h0000, busy || req.go, 8'h00, rd_byte};
         if (hit_map)  prdata = {vector_base, 11'h000, bus_join, 1'b0, 1'b0, bus_kind};
      end
   end
endmodule : ombc_top

// >>> design/ombc_regs.svh
`ifndef OMBC_REGS_SVH
`define OMBC_REGS_SVH
// Register byte offsets (printed offset 3 is not a multiple of four: index * 4)
`define OMBC_IDX_P2_DATA      8'h03
`define OMBC_ADDR_P2_DATA     12'h00c
`define OMBC_ADDR_P3_DATA     12'h100
`define OMBC_ADDR_P3_DIR      12'h104
`define OMBC_ADDR_P4_DATA     12'h108
`define OMBC_ADDR_P4_DIR      12'h10c
`define OMBC_ADDR_BUS_REQ     12'h110
`define OMBC_ADDR_BUS_STAT    12'h114
`define OMBC_ADDR_MAP_STAT    12'h118
// Field positions
`define OMBC_P2_MODE_LSB      5
`define OMBC_BUS_GO_BIT       16
`define OMBC_BUS_WR_BIT       17
// Reset values
`define OMBC_DIR_RESET        8'h00
`define OMBC_DATA_RESET       8'h00
// Modes and address windows
`define OMBC_MODE_TEST        3'h0
`define OMBC_MODE_PARTIAL     3'h1
`define OMBC_MODE_RAM_EXT     3'h2
`define OMBC_MODE_RELOC       3'h3
`define OMBC_MODE_NONUSER     3'h4
`define OMBC_MODE_NMUX        3'h5
`define OMBC_MODE_MUX_PART    3'h6
`define OMBC_MODE_SINGLE      3'h7
`define OMBC_IO_PAGE_HI       8'h01
`define OMBC_VEC_BASE_TEST    16'hbff0
`define OMBC_VEC_BASE_NORM    16'hfff0
`define OMBC_REG_BASE_RELOC   16'hd000
`define OMBC_REG_BASE_NORM    16'h0000
// E clock: 40 MHz / 40 = 1 MHz, E high for the second half
`define OMBC_E_DIV            6'd40
`define OMBC_E_HALF           6'd20
`define OMBC_AS_END           6'd8
`endif

// >>> design/ombc_pkg.sv
package ombc_pkg;
   typedef enum logic [1:0] {OMBC_BUS_SINGLE, OMBC_BUS_NMUX, OMBC_BUS_MUX, OMBC_BUS_NONE} ombc_bus_kind_t;
   typedef struct packed {
      logic [7:0] o;
      logic [7:0] oe;
   } ombc_pin_drv_t;
   typedef struct packed {
      logic        go;
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } ombc_bus_req_t;
endpackage : ombc_pkg

// >>> design/ombc_ecycle.sv
`timescale 1ns/1ps
`include "ombc_regs.svh"
// E clock phase generator and one external cycle sequencer
module ombc_ecycle (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire ombc_pkg::ombc_bus_req_t req,
   input  wire logic                   busy_in,
   output logic                        e_clk,
   output logic                        as_strobe,
   output logic                        e_last,
   output logic                        e_mid
);
   import ombc_pkg::*;
   logic [5:0] phase;
   logic [5:0] next_phase;

   // Free running divider; E and the strobe follow its phase
   assign next_phase = (phase == `OMBC_E_DIV - 6'd1) ? 6'd0 : phase + 6'd1;
   assign e_last     = (phase == `OMBC_E_DIV - 6'd1);
   assign e_mid      = (phase == `OMBC_E_HALF - 6'd1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase     <= 6'd0;
         e_clk     <= 1'b0;
         as_strobe <= 1'b0;
      end else begin
         phase     <= next_phase;
         e_clk     <= (next_phase >= `OMBC_E_HALF);
         // Strobe only for a real multiplexed cycle; falls while address still stands
         as_strobe <= busy_in && req.go && (next_phase > 6'd1) && (next_phase < `OMBC_AS_END);
      end
   end
endmodule : ombc_ecycle

// >>> dv/ombc_checker.sv
`timescale 1ns/1ps
`include "ombc_regs.svh"
// Timing and mapping relations on the top module's ports
module ombc_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic [11:0] paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic [7:0]  p4_pin_oe,
   input wire logic        p4_pullup_en,
   input wire logic        e_clk,
   input wire logic        addr_latch_strobe,
   input wire logic        io_page_select,
   input wire logic [2:0]  mode,
   input wire logic [15:0] vector_base,
   input wire logic [15:0] reg_base,
   input wire logic        bus_join
);
   logic [2:0] mode_q;
   logic [1:0] age;
   wire        rd_acc = psel & penable & ~pwrite;
   // Mode age; registered outputs lag, so only a settled mode is judged
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= 3'h0;
         age    <= 2'd0;
      end else begin
         mode_q <= mode;
         age    <= (mode != mode_q) ? 2'd0 : (age == 2'd3) ? age : age + 2'd1;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_as_rise;
      $rose(addr_latch_strobe);
   endsequence
   sequence s_as_pulse;
      addr_latch_strobe[*6] ##1 !addr_latch_strobe;
   endsequence
   a_p2_mode_read: assert property (rd_acc && paddr == `OMBC_ADDR_P2_DATA |-> prdata[7:5] == mode)
      else $error("mode field read back wrong");
   a_dir_write_only: assert property (rd_acc && (paddr == `OMBC_ADDR_P3_DIR || paddr == `OMBC_ADDR_P4_DIR)
      |-> pslverr) else $error("direction register readable");
   a_mode_one_way: assert property (age == 2'd3 && $changed(mode) |-> $past(mode) == 3'h0 && mode inside {3'h5,
      3'h6, 3'h7}) else $error("illegal mode change");
   a_vec_base: assert property (age == 2'd3 |-> vector_base == ((mode == 3'h0) ? 16'hbff0 : 16'hfff0))
      else $error("vector base wrong");
   a_reg_base: assert property (age == 2'd3 |-> reg_base == ((mode == 3'h3) ? 16'hd000 : 16'h0000))
      else $error("register base wrong");
   a_bus_join: assert property (age == 2'd3 |-> bus_join == (mode == 3'h0)) else $error("bus join wrong");
   a_mux_high_addr: assert property (age == 2'd3 && mode inside {3'h0, 3'h2, 3'h3} |-> p4_pin_oe == 8'hff)
      else $error("port 4 not driving high address");
   a_port4_pullup: assert property (age == 2'd3 && mode inside {3'h1, 3'h5, 3'h6} && p4_pin_oe == 8'h00
      |-> p4_pullup_en) else $error("port 4 pull-ups off");
   a_strobe_e_low: assert property (addr_latch_strobe |-> !e_clk && !(mode inside {3'h4, 3'h5, 3'h7}))
      else $error("strobe outside muxed address phase");
   a_strobe_width: assert property (s_as_rise |-> s_as_pulse) else $error("strobe width wrong");
   a_ios_decode: assert property (io_page_select |-> mode == 3'h5) else $error("io select outside mode 5");
endmodule : ombc_checker
bind ombc_top ombc_checker u_chk (.*);

// >>> dv/ombc_ext_mem.sv
`timescale 1ns/1ps
// External memory with address latch; answers reads with hi ^ lo of the address
module ombc_ext_mem (
   input  wire logic        e_clk,
   input  wire logic        addr_latch_strobe,
   input  wire logic        io_page_select,
   input  wire logic        bus_rd_wn,
   input  wire logic [7:0]  p3_pin_out,
   input  wire logic [7:0]  p3_pin_oe,
   input  wire logic [7:0]  p4_pin_out,
   input  wire logic [7:0]  p4_pin_oe,
   input  wire logic        p4_pullup_en,
   output logic [7:0]       p3_pin_in,
   output logic [7:0]       p4_pin_in,
   output logic [15:0]      wr_addr,
   output logic [7:0]       wr_data
);
   logic [7:0]  lat;
   logic        seen = 1'b0;
   wire         act  = seen | io_page_select;
   wire  [15:0] addr = io_page_select ? {8'h01, p4_pin_in} : {p4_pin_in, lat};
   // Strobe opens a transparent latch that keeps the low address
   always_latch begin
      if (addr_latch_strobe) lat <= p3_pin_out;
   end
   // A strobe marks a muxed cycle until E falls
   always @(posedge addr_latch_strobe or negedge e_clk) seen <= addr_latch_strobe;
   // Undriven port 4 lines rise on pull-ups, else show the inverse of the port 4 output
   assign p4_pin_in = (p4_pin_oe & p4_pin_out) | (~p4_pin_oe & (p4_pullup_en ? 8'hff : ~p4_pin_out));
   // Memory drives port 3 only in E high of its own read cycle
   assign p3_pin_in = (act & e_clk & bus_rd_wn) ? (addr[15:8] ^ addr[7:0]) : (p3_pin_oe & p3_pin_out) |
                      (~p3_pin_oe & ~p3_pin_out);
   // Write data is taken when E falls
   always @(negedge e_clk) begin
      if (act && !bus_rd_wn) begin
         wr_addr <= addr;
         wr_data <= p3_pin_out;
      end
   end
endmodule : ombc_ext_mem

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`include "ombc_regs.svh"
module tb_top;
   import ombc_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, p4_pullup_en, e_clk, addr_latch_strobe, io_page_select, bus_rd_wn, bus_join;
   logic [4:0]  p2_pin_in = 5'h00;
   logic [7:0]  p3_pin_in, p3_pin_out, p3_pin_oe, p4_pin_in, p4_pin_out, p4_pin_oe, wr_data;
   logic [2:0]  mode;
   logic [15:0] vector_base, reg_base, wr_addr;
   int          errors = 0, num_checks = 0, cyc = 0;
   ombc_top dut (.*);
   ombc_ext_mem u_mem (.*);
   initial forever #12.5 pclk = ~pclk;
   task tally_and_finish;
      $display("Checks %0d, errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish
   // Hang guard; the full run needs a few thousand cycles
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         errors++;
         tally_and_finish;
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer; request held until pready is seen high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Reset low for three E cycles, mode pins stable all through it
   task rst(input logic [2:0] m);
      presetn   <= 1'b0;
      p2_pin_in <= {2'b10, m};
      repeat (3 * `OMBC_E_DIV) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
   endtask : rst
   // External cycle request, then poll busy; rd holds the status word
   task ext(input logic w, input logic [15:0] a, input logic [7:0] d);
      apb(1'b1, `OMBC_ADDR_BUS_REQ, {d, 6'h00, w, 1'b1, a});
      do begin
         apb(1'b0, `OMBC_ADDR_BUS_STAT, 32'h0);
      end while (rd[16] !== 1'b0);
   endtask : ext
   initial begin
      logic [1:0] kind;
      // Every mode code: latch, readback, map and port 4 defaults
      for (int m = 0; m < 8; m++) begin
         kind = (m == 7) ? 2'd0 : (m == 5) ? 2'd1 : (m == 4) ? 2'd3 : 2'd2;
         rst(m[2:0]);
         apb(1'b0, `OMBC_ADDR_P2_DATA, 32'h0);
         chk(rd[7:0], {m[2:0], 2'b10, m[2:0]});
         apb(1'b0, `OMBC_ADDR_MAP_STAT, 32'h0);
         chk(rd & 32'hffff0013, {(m == 0) ? 16'hbff0 : 16'hfff0, 11'h0, m == 0, 2'b00, kind});
         chk(reg_base, (m == 3) ? 16'hd000 : 16'h0000);
         chk(p4_pin_oe, (m == 0 || m == 2 || m == 3) ? 8'hff : 8'h00);
      end
      // Single chip: direction bits, write-only, unmapped place
      apb(1'b1, `OMBC_ADDR_P3_DIR, 32'ha5);
      apb(1'b1, `OMBC_ADDR_P3_DATA, 32'h3c);
      repeat (2) @(posedge pclk);
      chk(p3_pin_oe, 8'ha5);
      chk(p3_pin_out & 8'ha5, 8'h24);
      apb(1'b0, `OMBC_ADDR_P3_DIR, 32'h0);
      chk(err, 1'b1);
      apb(1'b0, 12'h0f0, 32'h0);
      chk(err, 1'b1);
      ext(1'b0, 16'h0134, 8'h00);
      chk(p3_pin_oe, 8'ha5);
      // Nonmultiplexed: port 4 low address, data on port 3
      rst(3'h5);
      chk(p4_pullup_en, 1'b1);
      apb(1'b1, `OMBC_ADDR_P4_DIR, 32'hff);
      ext(1'b0, 16'h0134, 8'h00);
      chk(rd[7:0], 8'h35);
      chk(p4_pin_oe, 8'hff);
      ext(1'b1, 16'h0156, 8'h5a);
      chk({wr_addr, wr_data}, 24'h01565a);
      // Mode 1: pulled-up high byte, then a partial address subset
      rst(3'h1);
      ext(1'b0, 16'h0034, 8'h00);
      chk(rd[7:0], 8'hcb);
      apb(1'b1, `OMBC_ADDR_P4_DIR, 32'h0f);
      repeat (2) @(posedge pclk);
      chk(p4_pin_oe, 8'h0f);
      // Mode 2: muxed write then read
      rst(3'h2);
      ext(1'b1, 16'h1234, 8'h9c);
      chk({wr_addr, wr_data}, 24'h12349c);
      ext(1'b0, 16'hab12, 8'h00);
      chk(rd[7:0], 8'hb9);
      // Leaving mode 0: illegal code ignored, then no way back
      for (int m = 5; m < 8; m++) begin
         rst(3'h0);
         apb(1'b1, `OMBC_ADDR_P2_DATA, 32'h80);
         apb(1'b0, `OMBC_ADDR_P2_DATA, 32'h0);
         chk(rd[7:5], 3'h0);
         apb(1'b1, `OMBC_ADDR_P2_DATA, {24'h0, m[2:0], 5'h00});
         apb(1'b1, `OMBC_ADDR_P2_DATA, 32'h0);
         apb(1'b0, `OMBC_ADDR_P2_DATA, 32'h0);
         chk(rd[7:5], m[2:0]);
      end
      tally_and_finish;
   end
endmodule : tb_top
